/* File: src/wakeup_pkg.sv */
// Constants shared by the wake-up interval block and its divider.
// Assumes a single 10 MHz clock and an Avalon-MM master with word addressing.
package wakeup_pkg;
  localparam int ADDR_W = 2;
  localparam logic [ADDR_W-1:0] CTRL_STATUS_IDX = 2'h0;
  localparam logic [ADDR_W-1:0] EVENT_STATUS_IDX = 2'h1;
  localparam logic [ADDR_W-1:0] EVENT_MASK_IDX = 2'h2;
  localparam int FLAG_BIT = 7;
  localparam int FLAG_CLEAR_BIT = 6;
  localparam int INTERVAL_W = 6;
  localparam logic [INTERVAL_W-1:0] INTERVAL_RESET = 6'h3F;
  localparam logic [INTERVAL_W-1:0] INTERVAL_DISABLED = 6'h3F;
  localparam logic [INTERVAL_W-1:0] INTERVAL_ZERO = 6'h00;
  localparam int EVENT_W = 2;
  localparam int EV_WAKEUP_BIT = 0;
  localparam int EV_REFUSED_BIT = 1;
  localparam logic [EVENT_W-1:0] EVENT_RESET = 2'h0;
  localparam int PRESCALE_W = 11;
  localparam int PRESCALE_BASE = 504;
  localparam int PRESCALE_STEP = 16;
endpackage

/* File: src/div_if.sv */
// Carrier between the block and one of its interval dividers.
// Assumes tick_in and restart are one-cycle pulses in the clk domain.
`timescale 1ns/1ps
interface div_if #(parameter int W = 6);
  logic tick_in;
  logic restart;
  logic [W-1:0] limit;
  logic tick_out;
  modport ctrl (output tick_in, output restart, output limit, input tick_out);
  modport div (input tick_in, input restart, input limit, output tick_out);
endinterface

/* File: src/interval_divider.sv */
// Counts input ticks and emits one pulse every limit ticks, then reloads.
// Assumes limit is at least one; a zero limit wraps to the full count range.
`timescale 1ns/1ps
module interval_divider #(
  parameter int W = 6
) (
  input wire logic clk,
  input wire logic arst_n,
  div_if.div d
);
  logic [W-1:0] count_r;
  logic tick_out_r;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      count_r <= '0;
      tick_out_r <= 1'b0;
    end
    else if (d.restart)
    begin
      count_r <= '0;
      tick_out_r <= 1'b0;
    end
    else if (d.tick_in)
    begin
      // Reloading on the pulse keeps the stream periodic with no idle tick.
      if (count_r >= W'(d.limit - W'(1)))
      begin
        count_r <= '0;
        tick_out_r <= 1'b1;
      end
      else
      begin
        count_r <= W'(count_r + W'(1));
        tick_out_r <= 1'b0;
      end
    end
    else
    begin
      tick_out_r <= 1'b0;
    end
  end

  assign d.tick_out = tick_out_r;
endmodule // interval_divider

/* File: src/wakeup_interval_ctrl.sv */
// Wake-up interval control: interval field, sticky wake-up flag, interlock with the
// periodic-reset interval, tick prescaler and wake-up counter, Avalon-MM register slave.
// Assumes lfo_tick is a one-cycle pulse per nominal 1 ms and that the neighbouring
// periodic-reset part supplies its interval and due pulse in this clock domain.
`timescale 1ns/1ps
module wakeup_interval_ctrl #(
  parameter int INTERVAL_W = wakeup_pkg::INTERVAL_W,
  parameter int PRESCALE_W = wakeup_pkg::PRESCALE_W
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [wakeup_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic lfo_tick,
  input wire logic [5:0] tick_prescale,
  input wire logic [5:0] reset_interval,
  input wire logic reset_due,
  output logic wakeup_irq,
  output logic wakeup_period,
  output logic counter_restart,
  output logic reset_zero_allowed,
  output logic irq
);
  logic waitrequest_r;
  logic [31:0] readdata_r;
  logic [INTERVAL_W-1:0] interval_r;
  logic enable_r;
  logic wakeup_flag_r;
  logic counter_restart_r;
  logic reset_zero_allowed_r;
  logic wakeup_period_r;
  logic [wakeup_pkg::EVENT_W-1:0] event_status_r;
  logic [wakeup_pkg::EVENT_W-1:0] event_mask_r;
  logic irq_r;
  logic req;
  logic accept;
  logic wr_ctrl;
  logic wr_status;
  logic wr_mask;
  logic [INTERVAL_W-1:0] new_interval;
  logic [INTERVAL_W-1:0] held_interval;
  logic write_zero;
  logic zero_refused;
  logic interval_changed;
  logic flag_clear;
  logic wakeup_due;
  logic wakeup_raise;
  logic [wakeup_pkg::EVENT_W-1:0] event_set;
  logic [wakeup_pkg::EVENT_W-1:0] event_clear;

  div_if #(.W(PRESCALE_W)) pre_bus ();
  div_if #(.W(INTERVAL_W)) wake_bus ();

  // Decodes the register index into the word the bus returns.
  function automatic logic [31:0] read_word(
    input logic [wakeup_pkg::ADDR_W-1:0] idx,
    input logic flag,
    input logic [INTERVAL_W-1:0] field,
    input logic [wakeup_pkg::EVENT_W-1:0] status,
    input logic [wakeup_pkg::EVENT_W-1:0] mask
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    case (idx)
      wakeup_pkg::CTRL_STATUS_IDX:
      begin
        w[wakeup_pkg::FLAG_BIT] = flag;
        w[wakeup_pkg::FLAG_CLEAR_BIT] = 1'b0;
        w[INTERVAL_W-1:0] = field;
      end
      wakeup_pkg::EVENT_STATUS_IDX:
      begin
        w[wakeup_pkg::EVENT_W-1:0] = status;
      end
      wakeup_pkg::EVENT_MASK_IDX:
      begin
        w[wakeup_pkg::EVENT_W-1:0] = mask;
      end
      default:
      begin
        w = 32'h0000_0000;
      end
    endcase
    return w;
  endfunction

  // Decodes an accepted write on byte lane 0 to one register index.
  function automatic logic write_hit(
    input logic [wakeup_pkg::ADDR_W-1:0] idx,
    input logic acc,
    input logic wr,
    input logic lane0,
    input logic [wakeup_pkg::ADDR_W-1:0] addr
  );
    return acc & wr & lane0 & (addr == idx);
  endfunction

  // The bus answers every request after exactly one wait cycle.
  assign req = read | write;
  assign accept = req & ~waitrequest_r;

  // Waitrequest idles high, so every request spends one cycle in decode; the read word
  // is registered there at the cost of a second bus cycle per access.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      waitrequest_r <= 1'b1;
    end
    else
    begin
      waitrequest_r <= ~(req & waitrequest_r);
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      readdata_r <= 32'h0000_0000;
    end
    else if (read & waitrequest_r)
    begin
      readdata_r <= read_word(address, wakeup_flag_r, interval_r, event_status_r,
        event_mask_r);
    end
  end

  assign wr_ctrl = write_hit(wakeup_pkg::CTRL_STATUS_IDX, accept, write, byteenable[0],
    address);
  assign wr_status = write_hit(wakeup_pkg::EVENT_STATUS_IDX, accept, write, byteenable[0],
    address);
  assign wr_mask = write_hit(wakeup_pkg::EVENT_MASK_IDX, accept, write, byteenable[0],
    address);
  assign new_interval = writedata[INTERVAL_W-1:0];
  // A disabled wake-up counts as an all-zero field when comparing writes.
  assign held_interval = enable_r ? interval_r : wakeup_pkg::INTERVAL_ZERO;
  assign write_zero = wr_ctrl & (new_interval == wakeup_pkg::INTERVAL_ZERO);
  assign zero_refused = write_zero & (reset_interval == 6'h00);
  // A refused zero write leaves the field alone, so it cannot restart the counters either; its flag-clear bit still acts.
  assign interval_changed = wr_ctrl & ~zero_refused &
    (new_interval != held_interval);
  assign flag_clear = wr_ctrl & writedata[wakeup_pkg::FLAG_CLEAR_BIT];

  // Interval field and its enable.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      interval_r <= wakeup_pkg::INTERVAL_RESET;
      enable_r <= 1'b1;
    end
    else if (interval_changed)
    begin
      if (new_interval == wakeup_pkg::INTERVAL_ZERO)
      begin
        interval_r <= wakeup_pkg::INTERVAL_DISABLED;
        enable_r <= 1'b0;
      end
      else
      begin
        interval_r <= new_interval;
        enable_r <= 1'b1;
      end
    end
  end

  // One restart pulse serves the prescaler, the wake-up counter and the reset counter.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      counter_restart_r <= 1'b0;
    end
    else
    begin
      counter_restart_r <= interval_changed;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reset_zero_allowed_r <= 1'b1;
    end
    else
    begin
      // Follows the field after any accepted write, so it is current next cycle.
      reset_zero_allowed_r <= interval_changed ?
        (new_interval != wakeup_pkg::INTERVAL_ZERO) : enable_r;
    end
  end

  assign pre_bus.tick_in = lfo_tick;
  assign pre_bus.restart = counter_restart_r;
  assign pre_bus.limit = PRESCALE_W'(wakeup_pkg::PRESCALE_BASE +
    wakeup_pkg::PRESCALE_STEP * int'(tick_prescale));

  interval_divider #(.W(PRESCALE_W)) prescaler (
    .clk(clk),
    .arst_n(arst_n),
    .d(pre_bus)
  );

  assign wake_bus.tick_in = pre_bus.tick_out;
  assign wake_bus.restart = counter_restart_r;
  assign wake_bus.limit = interval_r;

  interval_divider #(.W(INTERVAL_W)) wake_counter (
    .clk(clk),
    .arst_n(arst_n),
    .d(wake_bus)
  );

  assign wakeup_due = wake_bus.tick_out & enable_r;
  // A periodic reset due in the same cycle swallows the interrupt; the reset restarts
  // the core anyway, so software still sees a fresh start.
  assign wakeup_raise = wakeup_due & ~reset_due;

  // The reset part counts interval periods even while the interrupt is disabled.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wakeup_period_r <= 1'b0;
    end
    else
    begin
      wakeup_period_r <= wake_bus.tick_out;
    end
  end

  // A wake-up in the same cycle as an acknowledge keeps the flag set.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wakeup_flag_r <= 1'b0;
    end
    else if (wakeup_raise)
    begin
      wakeup_flag_r <= 1'b1;
    end
    else if (flag_clear)
    begin
      wakeup_flag_r <= 1'b0;
    end
  end

  assign event_set[wakeup_pkg::EV_WAKEUP_BIT] = wakeup_raise;
  assign event_set[wakeup_pkg::EV_REFUSED_BIT] = zero_refused;
  assign event_clear = wr_status ?
    writedata[wakeup_pkg::EVENT_W-1:0] : '0;

  // Set wins over a write-one clear in the same cycle, so no event is ever lost.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      event_status_r <= wakeup_pkg::EVENT_RESET;
    end
    else
    begin
      event_status_r <= (event_status_r & ~event_clear) | event_set;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      event_mask_r <= wakeup_pkg::EVENT_RESET;
    end
    else if (wr_mask)
    begin
      event_mask_r <= writedata[wakeup_pkg::EVENT_W-1:0];
    end
  end

  // Registering the summary keeps irq free of glitches; it trails the status by a cycle.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irq_r <= 1'b0;
    end
    else
    begin
      irq_r <= |(event_status_r & event_mask_r);
    end
  end

  // The mask above only gates the summary line; the wake-up line cannot be masked.
  assign wakeup_irq = wakeup_flag_r;
  assign readdata = readdata_r;
  assign waitrequest = waitrequest_r;
  assign wakeup_period = wakeup_period_r;
  assign counter_restart = counter_restart_r;
  assign reset_zero_allowed = reset_zero_allowed_r;
  assign irq = irq_r;
endmodule // wakeup_interval_ctrl

/* File: testbench/wakeup_interval_ctrl_asserts.sv */
// Port-level checker for the wake-up interval block.
// Assumes it is bound into every instance of that block.
`timescale 1ns/1ps
module wakeup_interval_ctrl_chk #(
  parameter int INTERVAL_W = 6,
  parameter int PRESCALE_W = 11
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [wakeup_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic lfo_tick,
  input wire logic [5:0] tick_prescale,
  input wire logic [5:0] reset_interval,
  input wire logic reset_due,
  input wire logic wakeup_irq,
  input wire logic wakeup_period,
  input wire logic counter_restart,
  input wire logic reset_zero_allowed,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic acc_w;
  assign acc_w = write && !waitrequest && address == 2'h0 && byteenable[0];
  property p_wait_answer; (read || write) && waitrequest |=> !waitrequest; endproperty
  a_wait_answer: assert property (p_wait_answer) else $error("no answer");
  property p_wait_one; !waitrequest |=> waitrequest; endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait low too long");
  property p_flag_rise; $rose(wakeup_irq) |-> wakeup_period; endproperty
  a_flag_rise: assert property (p_flag_rise) else $error("flag without wake");
  property p_clear; $fell(wakeup_irq) |-> $past(acc_w && writedata[6]); endproperty
  a_clear: assert property (p_clear) else $error("flag cleared alone");
  property p_ack_zero;
    read && !waitrequest && address == 2'h0 |-> readdata[6] == 1'b0 && readdata[31:8] == 24'h0;
  endproperty
  a_ack_zero: assert property (p_ack_zero) else $error("clear bit read one");
  property p_restart; counter_restart |-> $past(acc_w); endproperty
  a_restart: assert property (p_restart) else $error("restart without write");
  property p_zero_ok;
    acc_w && writedata[5:0] == 6'h00 && reset_interval != 6'h00 |=> ##[0:1] !reset_zero_allowed;
  endproperty
  a_zero_ok: assert property (p_zero_ok) else $error("zero write not taken");
  property p_zero_refused;
    acc_w && writedata[5:0] == 6'h00 && reset_interval == 6'h00 && reset_zero_allowed
      |=> reset_zero_allowed [*2];
  endproperty
  a_zero_refused: assert property (p_zero_refused) else $error("zero write taken");
  property p_prio; wakeup_period && $past(reset_due) && !$past(wakeup_irq) |-> !wakeup_irq;
  endproperty
  a_prio: assert property (p_prio) else $error("wake beat reset");
  c_wake: cover property ($rose(wakeup_irq));
  c_restart: cover property (counter_restart);
  c_disable: cover property ($fell(reset_zero_allowed));
endmodule // wakeup_interval_ctrl_chk

bind wakeup_interval_ctrl wakeup_interval_ctrl_chk #(
  .INTERVAL_W(INTERVAL_W),
  .PRESCALE_W(PRESCALE_W)
) i_chk (.*);

/* File: testbench/reset_neighbour_model.sv */
// Model of the tick source and the neighbouring periodic-reset field.
// Assumes the bench commands it from the clk domain.
`timescale 1ns/1ps
module reset_neighbour_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic lfo_run,
  input wire logic due_hold,
  input wire logic [5:0] interval_req,
  input wire logic reset_zero_allowed,
  output logic lfo_tick,
  output logic [5:0] reset_interval,
  output logic reset_due
);
  // A tick every cycle keeps one wake tick at 504 cycles, which keeps the run short.
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      lfo_tick <= 1'b0;
    else
      lfo_tick <= lfo_run;
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      reset_interval <= 6'h3F;
    else if (interval_req != 6'h00 || reset_zero_allowed)
      reset_interval <= interval_req;
  // Holding the due line is a fault only the bench commands, to force a collision.
  assign reset_due = due_hold;
endmodule // reset_neighbour_model

/* File: testbench/tb_top.sv */
// Self-checking bench for the wake-up interval block.
// Assumes the checker and the neighbour model are compiled beside it.
`timescale 1ns/1ps
module tb_top;
  logic clk, arst_n, read, write, lfo_run, due_hold, lfo_tick, reset_due, waitrequest;
  logic wakeup_irq, wakeup_period, counter_restart, reset_zero_allowed, irq;
  logic [1:0] address;
  logic [3:0] byteenable;
  logic [31:0] writedata, readdata, rword;
  logic [5:0] interval_req, reset_interval, tick_prescale;
  int n_errors, check_count, n_restart, cyc, r0, cnt;
  wakeup_interval_ctrl i_wakeup_interval_ctrl (.clk(clk), .arst_n(arst_n), .address(address),
    .read(read), .write(write), .byteenable(byteenable), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .lfo_tick(lfo_tick),
    .tick_prescale(tick_prescale), .reset_interval(reset_interval), .reset_due(reset_due),
    .wakeup_irq(wakeup_irq), .wakeup_period(wakeup_period), .counter_restart(counter_restart),
    .reset_zero_allowed(reset_zero_allowed), .irq(irq));
  reset_neighbour_model i_reset_neighbour_model (.clk(clk), .arst_n(arst_n), .lfo_run(lfo_run),
    .due_hold(due_hold), .interval_req(interval_req), .reset_zero_allowed(reset_zero_allowed),
    .lfo_tick(lfo_tick), .reset_interval(reset_interval), .reset_due(reset_due));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Counting on the falling edge sees each pulse mid-cycle, clear of the task's edge.
  always @(negedge clk)
  begin
    n_restart += (counter_restart === 1'b1);
    cyc++;
    if (cyc == 50000)
    begin
      n_errors++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1)
    begin
      n_errors++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task automatic bus(input logic wr, input logic [1:0] a, input logic [7:0] d);
    address <= a;
    writedata <= {24'h000000, d};
    read <= !wr;
    write <= wr;
    do
      @(posedge clk);
    while (waitrequest !== 1'b0);
    rword = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wake_wait(input int lim);
    for (cnt = 0; cnt < lim && wakeup_irq !== 1'b1; cnt++)
      @(posedge clk);
  endtask
  task automatic t_reset_vals();
    bus(0, 2'h0, 8'h00);
    chk(rword === 32'h0000003F, "ctrl reset");
    bus(0, 2'h3, 8'h00);
    chk(rword === 32'h00000000, "unmapped");
  endtask
  task automatic t_wake();
    lfo_run <= 1'b1;
    r0 = n_restart;
    bus(1, 2'h0, 8'h01);
    chk(n_restart == r0 + 1, "no restart");
    wake_wait(700);
    chk(cnt > 500 && cnt < 515, "wake period");
    bus(1, 2'h0, 8'h01);
    chk(wakeup_irq === 1'b1 && n_restart == r0 + 1, "same write acted");
    bus(1, 2'h2, 8'h01);
    bus(0, 2'h1, 8'h00);
    chk(rword[0] === 1'b1 && irq === 1'b1, "event irq");
    bus(1, 2'h2, 8'h00);
    bus(1, 2'h1, 8'h01);
    chk(irq === 1'b0 && wakeup_irq === 1'b1, "mask");
    bus(1, 2'h0, 8'h41);
    chk(wakeup_irq === 1'b0, "clear");
    wake_wait(700);
    chk(cnt < 530, "no reload");
  endtask
  task automatic t_zero();
    tick_prescale <= 6'h01;
    bus(1, 2'h0, 8'h40);
    bus(0, 2'h0, 8'h00);
    chk(rword[5:0] === 6'h3F && reset_zero_allowed === 1'b0, "disable");
    // 63 wake ticks of 520 tick pulses each must pass before the first period pulse.
    for (cnt = 0; cnt < 33000 && wakeup_period !== 1'b1; cnt++)
      @(posedge clk);
    chk(cnt > 32700 && cnt < 32800, "prescaled period");
    chk(wakeup_irq === 1'b0, "disabled wake");
  endtask
  task automatic t_refuse();
    bus(1, 2'h0, 8'h02);
    interval_req <= 6'h00;
    repeat (3) @(posedge clk);
    bus(1, 2'h0, 8'h00);
    bus(0, 2'h0, 8'h00);
    chk(rword[5:0] === 6'h02 && reset_interval === 6'h00, "zero taken");
    bus(0, 2'h1, 8'h00);
    chk(rword[1] === 1'b1, "refusal event");
    interval_req <= 6'h3F;
  endtask
  task automatic t_prio();
    bus(1, 2'h0, 8'h01);
    due_hold <= 1'b1;
    wake_wait(1200);
    chk(wakeup_irq === 1'b0, "irq beside reset");
    due_hold <= 1'b0;
    wake_wait(700);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    bus(0, 2'h0, 8'h00);
    chk(rword === 32'h0000003F && cnt < 700, "mid reset");
  endtask
  initial
  begin
    {arst_n, read, write, lfo_run, due_hold} = 5'h00;
    address = 2'h0;
    byteenable = 4'hF;
    writedata = 32'h00000000;
    interval_req = 6'h3F;
    tick_prescale = 6'h00;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_reset_vals();
    t_wake();
    t_zero();
    t_refuse();
    t_prio();
    complete_run();
  end
endmodule // tb_top
